// ---- core/autoneg_adv_pkg.sv ----
// shared constants and types for the advertisement register block
package autoneg_adv_pkg;

	// ------------------------------------------------------------
	// register map and field positions
	// ------------------------------------------------------------
	localparam logic [4:0] adv_reg_addr = 5'h04;
	localparam int bit_next_page = 15;
	localparam int bit_resv_ack = 14;
	localparam int bit_remote_fault = 13;
	localparam int resv_hi = 12;
	localparam int resv_lo = 10;
	localparam int bit_t4 = 9;
	localparam int taf_hi = 8;
	localparam int taf_lo = 5;
	localparam int sel_hi = 4;
	localparam int sel_lo = 0;

	// ------------------------------------------------------------
	// values after reset
	// ------------------------------------------------------------
	localparam logic rst_next_page = 1'b0;
	localparam logic rst_remote_fault = 1'b0;
	localparam logic [3:0] rst_resv = 4'h0;
	localparam logic [3:0] rst_taf = 4'hf;
	localparam logic [4:0] rst_selector = 5'h01;
	localparam logic [2:0] rst_sync = 3'h0;
	localparam logic [3:0] all_abilities = 4'hf;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	// one management access, as handed over by the frame decoder
	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [15:0] wdata;
	} mgmt_req_t;

	// control-register and vendor-register bits that steer this block
	typedef struct packed {
		logic an_enable;
		logic rate_100;
		logic full_duplex;
		logic cmd_override;
	} mgmt_ctrl_t;

	// operating choice handed to the negotiation and link logic
	typedef struct packed {
		logic negotiate;
		logic speed_100;
		logic full_duplex;
	} link_mode_t;

endpackage

// ---- core/autoneg_advertisement_register.sv ----
// auto-negotiation advertisement register with strap-driven abilities
`timescale 1ns/1ps
// How it works
// - link code word built from register, sent
// - next-page bit read/write, resets to zero
// - bit 14 reads zero, written under override
// - bits 12:10 read zero, override writes only
// - remote fault set and cleared on local link problem edges
// - ability bit one means technology supported
// - 100Base-T4 ability always reads zero
// - abilities read-only hardware, override in software
// - hardware, negotiation pin low: forced idles
// - hardware, negotiation pin high: one ability
// - status capability bits always report everything
// - software, negotiation off: control bits choose mode
// - software negotiation advertises ability bits, default ones
// - selector resets to 00001, override writes, sent in code word
module autoneg_advertisement_register
	import autoneg_adv_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire mgmt_req_t mgmt_req,
	input wire mgmt_ctrl_t mgmt_ctrl,
	input wire logic local_fault,
	input wire logic config_source_pin,
	input wire logic negotiation_select_pin,
	input wire logic speed_select_pin,
	input wire logic duplex_select_pin,
	output logic [15:0] rd_data,
	output logic rd_valid,
	output logic [15:0] link_code_word,
	output logic code_word_valid,
	output link_mode_t link_mode,
	output logic [3:0] status_abilities
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0] sync_src;
		logic [2:0] sync_neg;
		logic [2:0] sync_spd;
		logic [2:0] sync_dpx;
		logic src;
		logic neg;
		logic spd;
		logic dpx;
		logic fault_seen;
		logic next_page;
		logic resv_ack;
		logic remote_fault;
		logic [2:0] resv;
		logic [3:0] technology_ability_field;
		logic [4:0] selector;
		logic [15:0] rd_data;
		logic rd_valid;
		logic [15:0] code_word;
		logic code_valid;
		link_mode_t mode;
		logic [3:0] status_ab;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	// three-stage pin synchroniser; stage 1 feeds only stage 2
	function automatic logic [2:0] sync_shift(input logic [2:0] s,
		input logic pin);
		sync_shift = {s[1:0], pin};
	endfunction

	// filtered level moves only once stages 2 and 3 agree
	function automatic logic filt(input logic [2:0] s, input logic cur);
		filt = (s[1] == s[2]) ? s[2] : cur;
	endfunction

	// one-hot ability from speed and duplex straps
	function automatic logic [3:0] one_ability(input logic spd,
		input logic dpx);
		case ({spd, dpx})
			2'b11: one_ability = 4'b1000;
			2'b10: one_ability = 4'b0100;
			2'b01: one_ability = 4'b0010;
			default: one_ability = 4'b0001;
		endcase
	endfunction

	// address decode shared by the read and write paths
	function automatic logic hits_adv(input logic [4:0] a);
		hits_adv = (a == adv_reg_addr);
	endfunction

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb begin
		logic wr_hit;
		logic ovr;
		logic [15:0] word;
		wr_hit = 1'b0;
		ovr = 1'b0;
		word = 16'h0000;
		st_nxt = st_r;

		// pins from outside the clock domain
		// straps may bounce at any time; the filter keeps a glitch
		// from rewriting the advertisement for a single cycle
		st_nxt.sync_src = sync_shift(st_r.sync_src, config_source_pin);
		st_nxt.sync_neg = sync_shift(st_r.sync_neg, negotiation_select_pin);
		st_nxt.sync_spd = sync_shift(st_r.sync_spd, speed_select_pin);
		st_nxt.sync_dpx = sync_shift(st_r.sync_dpx, duplex_select_pin);
		st_nxt.src = filt(st_r.sync_src, st_r.src);
		st_nxt.neg = filt(st_r.sync_neg, st_r.neg);
		st_nxt.spd = filt(st_r.sync_spd, st_r.spd);
		st_nxt.dpx = filt(st_r.sync_dpx, st_r.dpx);

		wr_hit = mgmt_req.wr && hits_adv(mgmt_req.addr);
		ovr = mgmt_ctrl.cmd_override;

		// plain read/write field
		if (wr_hit) begin
			st_nxt.next_page = mgmt_req.wdata[bit_next_page];
		end

		// reserved bits only take writes under command override
		if (wr_hit && ovr) begin
			st_nxt.resv_ack = mgmt_req.wdata[bit_resv_ack];
			st_nxt.resv = mgmt_req.wdata[resv_hi:resv_lo];
			st_nxt.selector = mgmt_req.wdata[sel_hi:sel_lo];
		end

		// fault edges win over a write in the same cycle
		// following the level would fight every write; edges still
		// let software clear a stale fault by hand
		st_nxt.fault_seen = local_fault;
		if (local_fault && !st_r.fault_seen) begin
			st_nxt.remote_fault = 1'b1;
		end else if (!local_fault && st_r.fault_seen) begin
			st_nxt.remote_fault = 1'b0;
		end else if (wr_hit) begin
			st_nxt.remote_fault = mgmt_req.wdata[bit_remote_fault];
		end

		// abilities: straps in hardware mode with negotiation pin high, override writes in software
		if (!st_r.src) begin
			if (st_r.neg) begin
				st_nxt.technology_ability_field = one_ability(st_r.spd, st_r.dpx);
			end
		end else if (wr_hit && ovr) begin
			st_nxt.technology_ability_field = mgmt_req.wdata[taf_hi:taf_lo];
		end

		// operating mode; in forced modes the abilities are left as is
		// limitation: no restart is raised here, software must restart
		// negotiation itself after it changes the abilities
		if (!st_r.src) begin
			st_nxt.mode.negotiate = st_r.neg;
			st_nxt.mode.speed_100 = st_r.spd;
			st_nxt.mode.full_duplex = st_r.dpx;
		end else begin
			st_nxt.mode.negotiate = mgmt_ctrl.an_enable;
			st_nxt.mode.speed_100 = mgmt_ctrl.rate_100;
			st_nxt.mode.full_duplex = mgmt_ctrl.full_duplex;
		end

		// code word: t4 bit is never advertised
		word[bit_next_page] = st_r.next_page;
		word[bit_resv_ack] = st_r.resv_ack;
		word[bit_remote_fault] = st_r.remote_fault;
		word[resv_hi:resv_lo] = st_r.resv;
		word[bit_t4] = 1'b0;
		word[taf_hi:taf_lo] = st_r.technology_ability_field;
		word[sel_hi:sel_lo] = st_r.selector;
		st_nxt.code_word = word;
		st_nxt.code_valid = st_r.mode.negotiate;

		// status capabilities never track the advertisement
		st_nxt.status_ab = all_abilities;

		// read answer one cycle later; reserved bits read as zero
		// they stay stored for the code word, only the read hides them
		st_nxt.rd_valid = mgmt_req.rd && hits_adv(mgmt_req.addr);
		if (mgmt_req.rd && hits_adv(mgmt_req.addr)) begin
			word[bit_resv_ack] = 1'b0;
			word[resv_hi:resv_lo] = 3'h0;
			st_nxt.rd_data = word;
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			st_r <= '0;
			st_r.sync_src <= rst_sync;
			st_r.sync_neg <= rst_sync;
			st_r.sync_spd <= rst_sync;
			st_r.sync_dpx <= rst_sync;
			st_r.next_page <= rst_next_page;
			st_r.remote_fault <= rst_remote_fault;
			st_r.resv_ack <= rst_resv[3];
			st_r.resv <= rst_resv[2:0];
			st_r.technology_ability_field <= rst_taf;
			st_r.selector <= rst_selector;
			st_r.status_ab <= all_abilities;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// outputs straight from flip-flops
	assign rd_data = st_r.rd_data;
	assign rd_valid = st_r.rd_valid;
	assign link_code_word = st_r.code_word;
	assign code_word_valid = st_r.code_valid;
	assign link_mode = st_r.mode;
	assign status_abilities = st_r.status_ab;

endmodule

// ---- bench/adv_reg_sva.sv ----
// port checker for the advertisement register
`timescale 1ns/1ps
module adv_reg_sva
	import autoneg_adv_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire mgmt_req_t mgmt_req,
	input wire logic config_source_pin,
	input wire logic negotiation_select_pin,
	input wire logic local_fault,
	input wire logic [15:0] rd_data,
	input wire logic rd_valid,
	input wire logic [15:0] link_code_word,
	input wire logic code_word_valid,
	input wire link_mode_t link_mode,
	input wire logic [3:0] status_abilities
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// ------------------------------------------------------------
	// write hit, then field, then code word
	// ------------------------------------------------------------
	sequence hit_wr;
		mgmt_req.wr && mgmt_req.addr == adv_reg_addr;
	endsequence
	a_read_answer: assert property (mgmt_req.rd && mgmt_req.addr == adv_reg_addr |=> rd_valid)
		else $error("read hit without answer");
	a_no_stray: assert property (mgmt_req.addr != adv_reg_addr |=> !rd_valid)
		else $error("answer without read hit");
	a_resv_read: assert property (rd_valid |-> rd_data[14] == 1'b0 && rd_data[12:9] == 4'h0)
		else $error("reserved bits read nonzero");
	a_np_write: assert property (hit_wr |-> ##2 link_code_word[15] == $past(mgmt_req.wdata[15], 2))
		else $error("next page write lost");
	// strap mode ignores ability writes; pins kept steady by the bench
	a_hw_lock: assert property (hit_wr ##0 !config_source_pin && !negotiation_select_pin |-> ##2 link_code_word[8:5] == $past(link_code_word[8:5], 2))
		else $error("ability written in hardware mode");
	a_cw_follows: assert property (1'b1 |=> code_word_valid == $past(link_mode.negotiate))
		else $error("code word valid off mode");
	a_status_all: assert property (status_abilities == all_abilities)
		else $error("status abilities changed");
	a_t4_clear: assert property (link_code_word[9] == 1'b0)
		else $error("t4 ability advertised");
	a_fault_set: assert property ($rose(local_fault) |-> ##[1:3] link_code_word[13])
		else $error("remote fault not sent");
endmodule
bind autoneg_advertisement_register adv_reg_sva chk (.*);

// ---- bench/mgmt_station.sv ----
// management station model issuing register accesses
`timescale 1ns/1ps
module mgmt_station
	import autoneg_adv_pkg::*;
(
	input wire logic clock,
	input wire logic [15:0] rd_data,
	input wire logic rd_valid,
	output mgmt_req_t mgmt_req
);
	initial mgmt_req = '0;
	// one-cycle strobe; answer taken while rd_valid stands
	task automatic access(input logic w, input logic [4:0] a,
		input logic [15:0] d, output logic ok, output logic [15:0] q);
		@(posedge clock);
		#1 mgmt_req = '{w, !w, a, d};
		@(posedge clock);
		#1 mgmt_req = '0;
		ok = rd_valid;
		q = rd_data;
	endtask
endmodule

// ---- bench/autoneg_advertisement_register_tb.sv ----
// self-checking bench for the advertisement register
`timescale 1ns/1ps
module autoneg_advertisement_register_tb;
	import autoneg_adv_pkg::*;
	logic clock = 0, rst = 1, local_fault = 0, ok;
	logic config_source_pin = 0, negotiation_select_pin = 0;
	logic speed_select_pin = 0, duplex_select_pin = 0;
	mgmt_req_t mgmt_req;
	mgmt_ctrl_t mgmt_ctrl = '0;
	logic [15:0] rd_data, link_code_word, q, e;
	logic rd_valid, code_word_valid;
	link_mode_t link_mode;
	logic [3:0] status_abilities;
	int n_fail = 0, n_compared = 0, cyc = 0;
	autoneg_advertisement_register dut (.*);
	mgmt_station management_station (.*);
	// ------------------------------------------------------------
	// clock, watchdog, shared checks
	// ------------------------------------------------------------
	initial forever #5 clock = ~clock;
	// a hung handshake ends the run as a failure
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			stop_test();
		end
	end
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic check(input logic [15:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [15:0] exp);
		management_station.access(0, adv_reg_addr, 16'h0000, ok, q);
		check({15'h0000, ok}, 16'h0001);
		check(q, exp);
	endtask
	task automatic stop_test;
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_access;
		rd_chk(16'h01e1);
		check({13'h0000, link_mode}, 16'h0000);
		management_station.access(1, adv_reg_addr, 16'hffff, ok, q);
		rd_chk(16'ha1e1);
		management_station.access(0, 5'h05, 16'h0000, ok, q);
		check({15'h0000, ok}, 16'h0000);
		mgmt_ctrl.cmd_override = 1;
		management_station.access(1, adv_reg_addr, 16'hffff, ok, q);
		rd_chk(16'ha1ff);
		management_station.access(1, adv_reg_addr, 16'h01e1, ok, q);
		step(2);
		check(link_code_word, 16'h01e1);
		$display("access test done");
	endtask
	task automatic t_straps;
		negotiation_select_pin = 1;
		for (int i = 0; i < 4; i++) begin
			{speed_select_pin, duplex_select_pin} = i[1:0];
			step(8);
			e = 16'h0001 | (16'h0020 << i);
			rd_chk(e);
			check(link_code_word, e);
			check({15'h0000, code_word_valid}, 16'h0001);
			check({13'h0000, link_mode}, {13'h0000, 1'b1, i[1:0]});
			check({12'h000, status_abilities}, 16'h000f);
		end
		negotiation_select_pin = 0;
		step(8);
		check({13'h0000, link_mode}, 16'h0003);
		check({15'h0000, code_word_valid}, 16'h0000);
		$display("strap test done");
	endtask
	task automatic t_soft;
		config_source_pin = 1;
		negotiation_select_pin = 0;
		mgmt_ctrl = '{1, 0, 0, 1};
		step(8);
		management_station.access(1, adv_reg_addr, 16'h0141, ok, q);
		rd_chk(16'h0141);
		check({15'h0000, link_mode.negotiate}, 16'h0001);
		local_fault = 1;
		step(3);
		rd_chk(16'h2141);
		local_fault = 0;
		mgmt_ctrl = '{0, 1, 0, 1};
		step(6);
		rd_chk(16'h0141);
		check({13'h0000, link_mode}, 16'h0002);
		check({15'h0000, code_word_valid}, 16'h0000);
		$display("software test done");
	endtask
	// main sequence: sixteen cycles of reset, then the scenarios
	initial begin
		step(16);
		rst = 0;
		t_access();
		t_straps();
		t_soft();
		stop_test();
	end
endmodule
